// file: logic/dsc_pkg.sv
// Shared constants for the serial chain converter front end
package dsc_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CODE_BITS = 18;
    localparam int CODE_LSB = 0;
    localparam int CNT_W = 6;
    localparam int CLK_SYS_PERIOD_NS = 5;
    localparam int LINK_PERIOD_NS = 160;
    localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / CLK_SYS_PERIOD_NS;
    localparam int CS_GAP_CYC = LINK_HALF_CYC * 2;
    localparam logic [17:0] CODE_RESET = 18'h00000;
    localparam int FIFO_DEPTH = 8;
endpackage

// file: logic/dsc_link_if.sv
// Serial link between the chain controller and the converter front end
interface dsc_link_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    modport ctrl (output sclk, output cs_n, output sdi, input sdo, input sdo_oe_n);
    modport conv (input sclk, input cs_n, input sdi, output sdo, output sdo_oe_n);
endinterface

// file: logic/dsc_conv.sv
// Converter end: chain shifter, input register and update latch
// How it works
// R1: Beyond 24 clocks, old bits leave serial out
// R2: Serial out changes on falling clock edge
// R3: Controller gives 24 clocks per chained device
// R4: Controller raises select after whole chain
// R5: Select rising copies shifter to input register
// R6: Continuous or burst clock, exact count
// R7: Input register loads only on valid frame
// R8: Latch code alone sets converter output
// R9: Strobe high holds latch
// R10: Strobe low makes latch transparent
// R11: Strobe tied low updates after select rises
// R12: Strobe falling later loads the latch
// R13: Shared strobe updates all outputs together
// R14: Shifter not cleared by reset
// R15: Select kept inactive during power up
// R16: 24-bit frame, low 18 bits code, MSB first
// R17: Sample data on rising clock edge
// R18: Short frame ignored, prior data kept
// R19: Mode pin low selects chained mode
// R20: 24-stage shifter, oldest stage drives out
module dsc_conv (
    input wire logic clk_sys,
    input wire logic rst_n,
    dsc_link_if.conv link,
    input wire logic latch_update_strobe_n,
    input wire logic serial_out_mode_select,
    output logic [17:0] code_out,
    output logic [17:0] input_reg_out,
    output logic frame_error
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_s_q, cs_s_q, sdi_s_q, ld_s_q, mode_s_q;
    logic sclk_d1_q, cs_d1_q;
    // Two stages on every pin; only the second stage is read
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_s_q <= 2'h0;
            cs_s_q <= 2'h3;
            sdi_s_q <= 2'h0;
            ld_s_q <= 2'h3;
            mode_s_q <= 2'h0;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[0], link.sclk};
            cs_s_q <= {cs_s_q[0], link.cs_n};
            sdi_s_q <= {sdi_s_q[0], link.sdi};
            ld_s_q <= {ld_s_q[0], latch_update_strobe_n};
            mode_s_q <= {mode_s_q[0], serial_out_mode_select};
        end
    end
    // Edge history taken from second stage only
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_d1_q <= 1'b0;
            cs_d1_q <= 1'b1;
        end
        else
        begin
            sclk_d1_q <= sclk_s_q[1];
            cs_d1_q <= cs_s_q[1];
        end
    end
    logic sel, rise, fall, cs_rise, chain_mode;
    assign sel = !cs_s_q[1];
    assign rise = sclk_s_q[1] && !sclk_d1_q && sel; // R17
    assign fall = !sclk_s_q[1] && sclk_d1_q && sel;
    assign cs_rise = cs_s_q[1] && !cs_d1_q;
    assign chain_mode = !mode_s_q[1]; // R19
    // ------------------------------------------------------------
    // Shift register (not reset, undefined until first frame)
    // ------------------------------------------------------------
    logic [dsc_pkg::FRAME_BITS-1:0] shift_q;
    // No reset on purpose: contents survive reset like the real part
    always_ff @(posedge clk_sys)
    begin
        if (rise)
            shift_q <= {shift_q[dsc_pkg::FRAME_BITS-2:0], sdi_s_q[1]}; // R14 R16 R20
    end
    // Count bits to tell short frames from full ones
    logic [dsc_pkg::CNT_W-1:0] cnt_q;
    logic full_q;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            full_q <= 1'b0;
        end
        else if (cs_rise)
        begin
            cnt_q <= '0;
            full_q <= 1'b0;
        end
        else if (rise && !full_q)
        begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == dsc_pkg::CNT_W'(dsc_pkg::FRAME_BITS - 1))
                full_q <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Serial out: oldest stage, launched on the falling edge
    // ------------------------------------------------------------
    logic sdo_q;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sdo_q <= 1'b0;
        else if (fall && chain_mode)
            sdo_q <= shift_q[dsc_pkg::FRAME_BITS-1]; // R1 R2 R20
    end
    assign link.sdo = sdo_q;
    // Drive only while selected in chained mode; released otherwise
    assign link.sdo_oe_n = !(sel && chain_mode);
    // ------------------------------------------------------------
    // Double buffer: input register then update latch
    // ------------------------------------------------------------
    logic [17:0] in_q, latch_q;
    logic err_q;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            in_q <= dsc_pkg::CODE_RESET;
        else if (cs_rise && full_q)
            in_q <= shift_q[dsc_pkg::CODE_BITS-1:0]; // R5 R7 R18
    end
    // Short frame flag, one pulse at select rise
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            err_q <= 1'b0;
        else
            err_q <= cs_rise && !full_q && (cnt_q != '0); // R18
    end
    // Latch follows input register while strobe low, holds while high
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            latch_q <= dsc_pkg::CODE_RESET;
        else if (!ld_s_q[1])
            latch_q <= in_q; // R10 R11 R12
        else
            latch_q <= latch_q; // R9
    end
    assign code_out = latch_q; // R8
    assign input_reg_out = in_q;
    assign frame_error = err_q;
endmodule

// file: logic/dsc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
module dsc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q, rp_q;
    logic push, pop;
    assign in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid = wp_q != rp_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rp_q[AW-1:0]];
    // Storage written on accepted words
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wp_q[AW-1:0]] <= in_data;
    end
    // Pointers carry one extra bit to tell full from empty
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
        end
    end
endmodule

// file: logic/dsc_ctrl.sv
// Controller end: sends buffered codes as chained 24-bit frames
module dsc_ctrl #(
    parameter int CHAIN_LEN = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    dsc_link_if.ctrl link,
    input wire logic code_valid,
    output logic code_ready,
    input wire logic [17:0] code_data,
    output logic latch_update_strobe_n,
    input wire logic update_hold,
    output logic busy
);
    logic f_valid, f_ready;
    logic [17:0] f_data;
    dsc_fifo #(.WIDTH(dsc_pkg::CODE_BITS), .DEPTH(dsc_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(code_valid),
        .in_ready(code_ready),
        .in_data(code_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );
    typedef enum logic [2:0] {IDLE, LOAD, LOW, HIGH, GAP} dsc_state_e;
    dsc_state_e st_q;
    localparam int TOTAL = dsc_pkg::FRAME_BITS * CHAIN_LEN;
    logic [dsc_pkg::FRAME_BITS*CHAIN_LEN-1:0] sh_q;
    logic [15:0] bits_q, div_q;
    logic [$clog2(CHAIN_LEN+1):0] words_q;
    // One word per chained device, oldest sent first so it lands in the last device
    assign f_ready = (st_q == LOAD);
    // Sequencer: exact 24 x chain clocks under one select low period
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= IDLE;
            sh_q <= '0;
            bits_q <= '0;
            div_q <= '0;
            words_q <= '0;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1; // R15
            link.sdi <= 1'b0;
            latch_update_strobe_n <= 1'b1; // R15
        end
        else
        begin
            case (st_q)
                IDLE:
                begin
                    latch_update_strobe_n <= 1'b1;
                    words_q <= '0;
                    if (f_valid)
                        st_q <= LOAD;
                end
                LOAD:
                begin
                    if (f_valid)
                    begin
                        // Shift by whole words so a chain of one needs no empty slice
                        sh_q <= (sh_q << dsc_pkg::FRAME_BITS) | TOTAL'({6'h00, f_data}); // R16
                        words_q <= words_q + 1'b1;
                        if (words_q == ($clog2(CHAIN_LEN+1)+1)'(CHAIN_LEN - 1))
                        begin
                            st_q <= LOW;
                            link.cs_n <= 1'b0;
                            bits_q <= 16'(TOTAL); // R3
                            div_q <= '0;
                        end
                    end
                end
                LOW:
                begin
                    // Data set while clock low, MSB first
                    link.sdi <= sh_q[TOTAL-1];
                    div_q <= div_q + 1'b1;
                    if (div_q == 16'(dsc_pkg::LINK_HALF_CYC - 1))
                    begin
                        link.sclk <= 1'b1;
                        sh_q <= {sh_q[TOTAL-2:0], 1'b0};
                        bits_q <= bits_q - 1'b1;
                        div_q <= '0;
                        st_q <= HIGH;
                    end
                end
                HIGH:
                begin
                    div_q <= div_q + 1'b1;
                    if (div_q == 16'(dsc_pkg::LINK_HALF_CYC - 1))
                    begin
                        link.sclk <= 1'b0;
                        div_q <= '0;
                        st_q <= (bits_q == '0) ? GAP : LOW; // R6
                    end
                end
                GAP:
                begin
                    // Burst done; select rises after a hold time
                    div_q <= div_q + 1'b1;
                    if (div_q == 16'(dsc_pkg::CS_GAP_CYC - 1))
                        link.cs_n <= 1'b1; // R4
                    if (div_q == 16'(dsc_pkg::CS_GAP_CYC * 2 - 1))
                    begin
                        // Shared strobe pulse updates every latch at once
                        latch_update_strobe_n <= update_hold; // R13
                    end
                    if (div_q == 16'(dsc_pkg::CS_GAP_CYC * 3 - 1))
                        st_q <= IDLE;
                end
                default:
                    st_q <= IDLE;
            endcase
        end
    end
    assign busy = (st_q != IDLE);
endmodule

// file: verif/dsc_link_asserts.sv
// Checker on the serial link between controller and converter ends
module dsc_link_asserts #(
    parameter int CHAIN_LEN = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    logic [7:0] hi_q;
    logic [7:0] rise_q;
    // -----------------------------------
    // Helper counters
    // -----------------------------------
    // Cycles the link clock has stood high
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            hi_q <= 8'h00;
        else
            hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
    end
    // Link clock rises within the current frame
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rise_q <= 8'h00;
        else if (cs_n)
            rise_q <= 8'h00;
        else if ($rose(sclk))
            rise_q <= rise_q + 8'h01;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // -----------------------------------
    // Properties
    // -----------------------------------
    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("link clock moved while deselected");
    a_frame_len: assert property ($rose(cs_n) |-> rise_q == 24 * CHAIN_LEN)
        else $error("wrong clock count in frame");
    a_sclk_width: assert property ($fell(sclk) |-> hi_q == dsc_pkg::LINK_HALF_CYC)
        else $error("link clock high phase wrong");
    a_sdi_hold: assert property (sclk && !cs_n |-> $stable(sdi))
        else $error("data moved while clock high");
    a_pad_zero: assert property ($rose(sclk) && rise_q < 6 |-> !sdi)
        else $error("pad bit not zero");
    a_sdo_fall: assert property ($changed(sdo) && !cs_n |-> !sclk)
        else $error("serial out moved while clock high");
    a_oe_off: assert property (cs_n && $past(cs_n, 4) |-> sdo_oe_n)
        else $error("serial out driven while deselected");
    a_oe_on: assert property (!cs_n && !$past(cs_n, 4) |-> !sdo_oe_n)
        else $error("serial out not driven in frame");
endmodule

// file: verif/tb.sv
// Testbench: controller and converter ends, plus a bench-driven converter
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0;
    logic rst_n = 0;
    logic code_valid = 0;
    logic code_ready;
    logic [17:0] code_data = 18'h00000;
    logic stb_n;
    logic update_hold = 0;
    logic busy;
    logic [17:0] code_a;
    logic [17:0] ireg_a;
    logic [17:0] code_b;
    logic [17:0] ireg_b;
    logic stb_b = 1;
    logic [17:0] lf = 18'h0001d;
    logic [17:0] prev_a = 18'h00000;
    logic [17:0] expq[$];
    logic saw_full = 0;
    logic err_b;
    logic saw_err = 0;
    int err_count = 0;
    int total_checks = 0;
    dsc_link_if la();
    dsc_link_if lb();
    dsc_ctrl #(.CHAIN_LEN(1)) u_dsc_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .link(la),
        .code_valid(code_valid), .code_ready(code_ready), .code_data(code_data),
        .latch_update_strobe_n(stb_n), .update_hold(update_hold), .busy(busy));
    dsc_conv u_dsc_conv (.clk_sys(clk_sys), .rst_n(rst_n), .link(la),
        .latch_update_strobe_n(stb_n), .serial_out_mode_select(1'b0),
        .code_out(code_a), .input_reg_out(ireg_a), .frame_error());
    dsc_conv u_dsc_conv_2 (.clk_sys(clk_sys), .rst_n(rst_n), .link(lb),
        .latch_update_strobe_n(stb_b), .serial_out_mode_select(1'b0),
        .code_out(code_b), .input_reg_out(ireg_b), .frame_error(err_b));
    dsc_link_asserts #(.CHAIN_LEN(1)) u_dsc_link_asserts (.clk_sys(clk_sys),
        .rst_n(rst_n), .sclk(la.sclk), .cs_n(la.cs_n), .sdi(la.sdi),
        .sdo(la.sdo), .sdo_oe_n(la.sdo_oe_n));
    // System clock
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Repeatable random source
    function automatic logic [17:0] step(input logic [17:0] s);
        return {s[16:0], s[17] ^ s[10]};
    endfunction
    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Push one code, holding valid until the edge that sees ready
    task automatic push(input logic [17:0] c);
        @(posedge clk_sys);
        #1;
        code_valid = 1;
        code_data = c;
        expq.push_back(c);
        while (code_ready !== 1'b1)
        begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        #1;
        code_valid = 0;
    endtask
    // Wait until the controller has stayed idle a while
    task automatic idle();
        int n;
        n = 0;
        while (n < 64)
        begin
            @(posedge clk_sys);
            #1;
            n = (busy === 1'b0) ? n + 1 : 0;
        end
    endtask
    // Bench frame on the second link; the clock only runs inside the frame
    task automatic send(input int n, input logic [31:0] d);
        lb.cs_n = 0;
        for (int i = 0; i < n; i++)
        begin
            lb.sdi = d[n-1-i];
            #80;
            if (i >= 24) chk({17'h0, lb.sdo}, {17'h0, d[n+23-i]}, "chain out");
            lb.sclk = 1;
            #80;
            lb.sclk = 0;
        end
        #80;
        lb.cs_n = 1;
        lb.sdi = ~lb.sdi;
        repeat (10) @(posedge clk_sys);
        #1;
    endtask
    // Each input register change must be the next queued code, in order
    always @(posedge clk_sys)
    begin
        if (rst_n && ireg_a !== prev_a)
        begin
            chk(ireg_a, (expq.size() > 0) ? expq.pop_front() : 'x, "order");
            prev_a = ireg_a;
        end
        if (rst_n && code_ready === 1'b0)
            saw_full = 1;
        if (rst_n && err_b === 1'b1)
            saw_err = 1;
    end
    // Watchdog sized well past the expected run
    initial
    begin
        #400000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
    // Main sequence
    initial
    begin
        lb.sclk = 0;
        lb.cs_n = 1;
        lb.sdi = 0;
        repeat (10) @(posedge clk_sys);
        #1;
        rst_n = 1;
        push(18'h3ffff);
        push(18'h00000);
        for (int i = 0; i < 10; i++)
        begin
            lf = step(lf);
            push(lf);
        end
        idle();
        chk(code_a, lf, "latch follows");
        chk({17'h0, saw_full}, 18'h1, "fifo refused");
        chk(18'(expq.size()), 18'h0, "frames lost");
        $display("test queue done");
        update_hold = 1;
        push(18'h2a5a5);
        idle();
        chk(ireg_a, 18'h2a5a5, "hold input");
        chk(code_a, lf, "hold latch");
        update_hold = 0;
        $display("test hold done");
        lf = step(lf);
        send(24, {14'h0, lf});
        chk(ireg_b, lf, "frame load");
        chk(code_b, 18'h0, "latch held");
        chk({17'h0, saw_err}, 18'h0, "no flag on full frame");
        stb_b = 0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk(code_b, lf, "latch open");
        send(20, {12'h0, ~lf[17:0], 2'h0});
        chk(ireg_b, lf, "short frame");
        chk({17'h0, saw_err}, 18'h1, "short frame flagged");
        lf = step(lf);
        send(30, {2'h0, lf[11:0], lf});
        chk(ireg_b, lf, "long frame");
        chk(code_b, lf, "transparent");
        stb_b = 1;
        $display("test chain done");
        finish_test();
    end
endmodule
